/* File: hw/flash_bank_two_pkg.sv */
// constants and types shared by the second-bank flash controller
package flash_bank_two_pkg;

  // register byte offsets
  localparam logic [11:0] UNLOCK_KEY_OFF  = 12'h044;
  localparam logic [11:0] STATUS_OFF      = 12'h04c;
  localparam logic [11:0] CONTROL_OFF     = 12'h050;
  localparam logic [11:0] TARGET_ADDR_OFF = 12'h054;
  localparam logic [11:0] FETCH_WAIT_OFF  = 12'h058;
  localparam logic [11:0] PRODUCT_ID_OFF  = 12'h100;

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PROGRAM_ERROR_FLAG_BIT = 2;
  localparam int STAT_PROT_BIT = 4;
  localparam int STAT_DONE_BIT = 5;

  // control field positions
  localparam int CTL_PROGRAM_BIT = 0;
  localparam int CTL_PAGE_ERASE_BIT = 1;
  localparam int CTL_MASS_ERASE_BIT = 2;
  localparam int CTL_START_BIT = 6;
  localparam int CTL_LOCK_BIT = 7;
  localparam int CTL_ERR_IE_BIT = 10;
  localparam int CTL_DONE_IE_BIT = 12;

  // fetch wait / bit program field positions
  localparam int WS_FETCH_WAIT_BIT = 0;
  localparam int WS_BIT_PROG_BIT = 1;

  // reset values
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0080;
  localparam logic [31:0] TARGET_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] FETCH_WAIT_RST = 32'h0000_0000;

  // unlock key words, in order
  localparam logic [31:0] UNLOCK_KEY_FIRST = 32'h4567_0123;
  localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hcdef_89ab;

  // content of an erased half-word
  localparam logic [15:0] ERASED_VALUE = 16'hffff;

  // product identifier, value arbitrary
  localparam logic [31:0] PRODUCT_ID_VALUE = 32'h0a5c_0001;

  // operation kinds handed to the array
  typedef enum logic [1:0] {
    OP_PROGRAM    = 2'h0,
    OP_PAGE_ERASE = 2'h1,
    OP_MASS_ERASE = 2'h2
  } op_kind_t;

  // operation engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } eng_state_t;

endpackage : flash_bank_two_pkg

/* File: hw/flash_op_if.sv */
// request and result signals between the register file and the operation engine
interface flash_op_if;
  logic                         req;
  flash_bank_two_pkg::op_kind_t kind;
  logic [31:0]                  addr;
  logic [15:0]                  data;
  logic                         bit_prog;
  logic                         busy;
  logic                         finish;
  logic                         ok;
  logic                         prot_err;
  logic                         prog_err;

  modport ctrl (output req, kind, addr, data, bit_prog,
                input busy, finish, ok, prot_err, prog_err);
  modport engine (input req, kind, addr, data, bit_prog,
                  output busy, finish, ok, prot_err, prog_err);
endinterface : flash_op_if

/* File: hw/flash_op_engine.sv */
// sequences one erase or program operation against the flash array
module flash_op_engine (
  input  wire logic                         clk,
  input  wire logic                         rst,
  flash_op_if.engine                        op,
  input  wire logic                         page_protected,
  input  wire logic [15:0]                  array_cur_data,
  input  wire logic                         array_done,
  output logic                              array_start,
  output flash_bank_two_pkg::op_kind_t      array_kind,
  output logic [31:0]                       array_addr,
  output logic [15:0]                       array_wdata
);

  flash_bank_two_pkg::eng_state_t state_r;
  logic not_erased;
  logic reject;

  assign not_erased = op.kind == flash_bank_two_pkg::OP_PROGRAM && !op.bit_prog
                      && array_cur_data != flash_bank_two_pkg::ERASED_VALUE; // RQ3 RQ15
  assign reject = page_protected || not_erased;

  assign op.busy = state_r == flash_bank_two_pkg::ENG_RUN; // RQ4

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= flash_bank_two_pkg::ENG_IDLE;
    end else begin
      unique case (state_r)
        flash_bank_two_pkg::ENG_IDLE: begin
          if (op.req && !reject) begin
            state_r <= flash_bank_two_pkg::ENG_RUN;
          end
        end
        flash_bank_two_pkg::ENG_RUN: begin
          if (array_done) begin
            state_r <= flash_bank_two_pkg::ENG_IDLE;
          end
        end
        default: state_r <= flash_bank_two_pkg::ENG_IDLE;
      endcase
    end
  end

  // one-cycle results, errors end the request without going busy
  always_ff @(posedge clk) begin
    if (rst) begin
      op.finish <= 1'b0;
      op.ok <= 1'b0;
      op.prot_err <= 1'b0;
      op.prog_err <= 1'b0;
    end else begin
      op.finish <= (op.req && reject && state_r == flash_bank_two_pkg::ENG_IDLE) ||
                   (array_done && state_r == flash_bank_two_pkg::ENG_RUN);
      op.ok <= array_done && state_r == flash_bank_two_pkg::ENG_RUN;
      op.prot_err <= op.req && page_protected && state_r == flash_bank_two_pkg::ENG_IDLE; // RQ2
      op.prog_err <= op.req && !page_protected && not_erased &&
                     state_r == flash_bank_two_pkg::ENG_IDLE; // RQ3
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      array_start <= 1'b0;
      array_kind <= flash_bank_two_pkg::OP_PROGRAM;
      array_addr <= 32'h0000_0000;
      array_wdata <= 16'h0000;
    end else begin
      array_start <= op.req && !reject && state_r == flash_bank_two_pkg::ENG_IDLE;
      if (op.req && state_r == flash_bank_two_pkg::ENG_IDLE) begin
        array_kind <= op.kind;
        array_addr <= op.addr;
        array_wdata <= op.data;
      end
    end
  end

endmodule : flash_op_engine

/* File: hw/flash_bank_two_ctrl.sv */
// register file and command launch for the second flash bank
//
// Design decision made here: the address-and-strobe port.

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1 - done flag, status bit 5, set on successful finish; write one clears
// RQ2 - protection error flag, status bit 4, set on protected target; write one clears
// RQ3 - program error flag, status bit 2, set when target not erased; write one clears
// RQ4 - busy, status bit 0, high during operation, low at end or error
// RQ5 - control bit 12 enables the done interrupt
// RQ6 - control bit 10 enables the error interrupt
// RQ7 - lock bit 7 resets to one, cleared by key sequence, software may set
// RQ8 - software writes both key words before changing fetch wait enable
// RQ9 - start bit 6 launches erase; hardware clears it when busy drops
// RQ10 - control bit 2 selects mass erase of the whole bank
// RQ11 - control bit 1 selects erase of the page at target address
// RQ12 - control bit 0 turns bank writes into program commands
// RQ13 - software returns control register to reset value after completion
// RQ14 - target address register holds the erase and program address
// RQ15 - bit program enable one skips the erased check
// RQ16 - fetch wait enable one adds a wait state to instruction fetch
// RQ17 - product identifier register is a read-only constant
// RQ18 - software uses full word accesses only
// RQ19 - unlock key register at 0x44 is write only
// RQ20 - while locked, command and interrupt enable writes are ignored
// RQ21 - interrupt high while an enabled flag is set
module flash_bank_two_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [11:0]                  reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [31:0]                       reg_rdata,
  input  wire logic                         bank_wr,
  input  wire logic [15:0]                  bank_wdata,
  input  wire logic                         page_protected,
  input  wire logic [15:0]                  array_cur_data,
  input  wire logic                         array_done,
  output logic                              array_start,
  output flash_bank_two_pkg::op_kind_t      array_kind,
  output logic [31:0]                       array_addr,
  output logic [15:0]                       array_wdata,
  output logic                              fetch_wait_state,
  output logic                              irq
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helper

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = a == off;
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  flash_op_if op ();

  logic        wr_key;
  logic        wr_status;
  logic        wr_control;
  logic        wr_target;
  logic        wr_fetch;

  logic        control_lock_r;
  logic        key_first_seen_r;
  logic        done_irq_enable_r;
  logic        error_irq_enable_r;
  logic        start_r;
  logic        mass_erase_cmd_r;
  logic        page_erase_cmd_r;
  logic        program_cmd_r;
  logic [31:0] bank2_target_address_r;
  logic        fetch_wait_enable_r;
  logic        bit_program_enable_r;

  logic [2:0]  flag_r;
  logic [2:0]  flag_set;
  logic [2:0]  flag_clr;

  logic        erase_launch;
  logic        program_launch;
  logic        start_nxt;

  logic [31:0] status_view;
  logic [31:0] control_view;
  logic [31:0] fetch_view;
  logic [31:0] rdata_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // write decode

  assign wr_key     = reg_wr && hit(reg_addr, flash_bank_two_pkg::UNLOCK_KEY_OFF);
  assign wr_status  = reg_wr && hit(reg_addr, flash_bank_two_pkg::STATUS_OFF);
  assign wr_control = reg_wr && hit(reg_addr, flash_bank_two_pkg::CONTROL_OFF);
  assign wr_target  = reg_wr && hit(reg_addr, flash_bank_two_pkg::TARGET_ADDR_OFF);
  assign wr_fetch   = reg_wr && hit(reg_addr, flash_bank_two_pkg::FETCH_WAIT_OFF);

  //////////////////////////////////////////////////////////////////////////////
  // lock and key sequence

  // a wrong word or any other order restarts the sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      key_first_seen_r <= 1'b0;
    end else if (wr_key) begin
      key_first_seen_r <= reg_wdata == flash_bank_two_pkg::UNLOCK_KEY_FIRST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control_lock_r <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_LOCK_BIT]; // RQ7
    end else if (wr_control && reg_wdata[flash_bank_two_pkg::CTL_LOCK_BIT]) begin
      control_lock_r <= 1'b1; // RQ7
    end else if (wr_key && key_first_seen_r &&
                 reg_wdata == flash_bank_two_pkg::UNLOCK_KEY_SECOND) begin
      control_lock_r <= 1'b0; // RQ7
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk) begin
    if (rst) begin
      done_irq_enable_r  <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_DONE_IE_BIT];
      error_irq_enable_r <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_ERR_IE_BIT];
    end else if (wr_control && !control_lock_r) begin // RQ20
      done_irq_enable_r  <= reg_wdata[flash_bank_two_pkg::CTL_DONE_IE_BIT]; // RQ5
      error_irq_enable_r <= reg_wdata[flash_bank_two_pkg::CTL_ERR_IE_BIT]; // RQ6
    end
  end

  // command selects are frozen while the start bit is set
  always_ff @(posedge clk) begin
    if (rst) begin
      mass_erase_cmd_r <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_MASS_ERASE_BIT];
      page_erase_cmd_r <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_PAGE_ERASE_BIT];
      program_cmd_r    <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_PROGRAM_BIT];
    end else if (wr_control && !control_lock_r && !start_r) begin // RQ20
      mass_erase_cmd_r <= reg_wdata[flash_bank_two_pkg::CTL_MASS_ERASE_BIT]; // RQ10
      page_erase_cmd_r <= reg_wdata[flash_bank_two_pkg::CTL_PAGE_ERASE_BIT]; // RQ11
      program_cmd_r    <= reg_wdata[flash_bank_two_pkg::CTL_PROGRAM_BIT]; // RQ12
    end
  end

  // start rises only on a write of one while unlocked and idle
  assign erase_launch = wr_control && !control_lock_r && !start_r && !op.busy &&
                        reg_wdata[flash_bank_two_pkg::CTL_START_BIT] &&
                        (reg_wdata[flash_bank_two_pkg::CTL_MASS_ERASE_BIT] ||
                         reg_wdata[flash_bank_two_pkg::CTL_PAGE_ERASE_BIT]); // RQ9

  always_comb begin
    start_nxt = start_r;
    if (erase_launch) begin
      start_nxt = 1'b1;
    end else if (op.finish) begin
      start_nxt = 1'b0; // RQ9
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_r <= flash_bank_two_pkg::CONTROL_RST[flash_bank_two_pkg::CTL_START_BIT];
    end else begin
      start_r <= start_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // target address and fetch wait register

  always_ff @(posedge clk) begin
    if (rst) begin
      bank2_target_address_r <= flash_bank_two_pkg::TARGET_ADDR_RST;
    end else if (wr_target && !op.busy) begin
      bank2_target_address_r <= reg_wdata; // RQ14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_program_enable_r <= flash_bank_two_pkg::FETCH_WAIT_RST[flash_bank_two_pkg::WS_BIT_PROG_BIT];
    end else if (wr_fetch) begin
      bit_program_enable_r <= reg_wdata[flash_bank_two_pkg::WS_BIT_PROG_BIT]; // RQ15
    end
  end

  // the wait enable only moves once the key sequence has unlocked the bank
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_wait_enable_r <= flash_bank_two_pkg::FETCH_WAIT_RST[flash_bank_two_pkg::WS_FETCH_WAIT_BIT];
    end else if (wr_fetch && !control_lock_r) begin // RQ8
      fetch_wait_enable_r <= reg_wdata[flash_bank_two_pkg::WS_FETCH_WAIT_BIT];
    end
  end

  assign fetch_wait_state = fetch_wait_enable_r; // RQ16

  //////////////////////////////////////////////////////////////////////////////
  // operation requests

  // a bank write is a program command only with the program select set
  assign program_launch = bank_wr && program_cmd_r && !op.busy && !start_r; // RQ12

  always_comb begin
    op.req = erase_launch || program_launch;
    op.kind = flash_bank_two_pkg::OP_PROGRAM;
    if (erase_launch) begin
      if (reg_wdata[flash_bank_two_pkg::CTL_MASS_ERASE_BIT]) begin
        op.kind = flash_bank_two_pkg::OP_MASS_ERASE; // RQ10
      end else begin
        op.kind = flash_bank_two_pkg::OP_PAGE_ERASE; // RQ11
      end
    end
    op.addr = bank2_target_address_r; // RQ14
    op.data = bank_wdata;
    op.bit_prog = bit_program_enable_r; // RQ15
  end

  flash_op_engine engine_u (
    .clk            (clk),
    .rst            (rst),
    .op             (op),
    .page_protected (page_protected),
    .array_cur_data (array_cur_data),
    .array_done     (array_done),
    .array_start    (array_start),
    .array_kind     (array_kind),
    .array_addr     (array_addr),
    .array_wdata    (array_wdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sticky status flags: index 0 program error, 1 protection, 2 done

  assign flag_set = {op.ok, op.prot_err, op.prog_err}; // RQ1 RQ2 RQ3
  assign flag_clr = {3{wr_status}} &
                    {reg_wdata[flash_bank_two_pkg::STAT_DONE_BIT],
                     reg_wdata[flash_bank_two_pkg::STAT_PROT_BIT],
                     reg_wdata[flash_bank_two_pkg::STAT_PROGRAM_ERROR_FLAG_BIT]};

  for (genvar i = 0; i < 3; i++) begin : g_flag
    // a set in the clearing cycle wins
    always_ff @(posedge clk) begin
      if (rst) begin
        flag_r[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flag_r[i] <= 1'b1; // RQ1 RQ2 RQ3
      end else if (flag_clr[i]) begin
        flag_r[i] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (flag_r[2] && done_irq_enable_r) ||
             ((flag_r[1] || flag_r[0]) && error_irq_enable_r); // RQ5 RQ6 RQ21
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    status_view = flash_bank_two_pkg::STATUS_RST;
    status_view[flash_bank_two_pkg::STAT_BUSY_BIT] = op.busy; // RQ4
    status_view[flash_bank_two_pkg::STAT_PROGRAM_ERROR_FLAG_BIT] = flag_r[0];
    status_view[flash_bank_two_pkg::STAT_PROT_BIT] = flag_r[1];
    status_view[flash_bank_two_pkg::STAT_DONE_BIT] = flag_r[2];
  end

  always_comb begin
    control_view = 32'h0000_0000;
    control_view[flash_bank_two_pkg::CTL_PROGRAM_BIT] = program_cmd_r;
    control_view[flash_bank_two_pkg::CTL_PAGE_ERASE_BIT] = page_erase_cmd_r;
    control_view[flash_bank_two_pkg::CTL_MASS_ERASE_BIT] = mass_erase_cmd_r;
    control_view[flash_bank_two_pkg::CTL_START_BIT] = start_r;
    control_view[flash_bank_two_pkg::CTL_LOCK_BIT] = control_lock_r;
    control_view[flash_bank_two_pkg::CTL_ERR_IE_BIT] = error_irq_enable_r;
    control_view[flash_bank_two_pkg::CTL_DONE_IE_BIT] = done_irq_enable_r;
  end

  always_comb begin
    fetch_view = 32'h0000_0000;
    fetch_view[flash_bank_two_pkg::WS_FETCH_WAIT_BIT] = fetch_wait_enable_r;
    fetch_view[flash_bank_two_pkg::WS_BIT_PROG_BIT] = bit_program_enable_r;
  end

  // key register reads as zero, unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(reg_addr, flash_bank_two_pkg::STATUS_OFF)) begin
      rdata_nxt = status_view;
    end else if (hit(reg_addr, flash_bank_two_pkg::CONTROL_OFF)) begin
      rdata_nxt = control_view;
    end else if (hit(reg_addr, flash_bank_two_pkg::TARGET_ADDR_OFF)) begin
      rdata_nxt = bank2_target_address_r;
    end else if (hit(reg_addr, flash_bank_two_pkg::FETCH_WAIT_OFF)) begin
      rdata_nxt = fetch_view;
    end else if (hit(reg_addr, flash_bank_two_pkg::PRODUCT_ID_OFF)) begin
      rdata_nxt = flash_bank_two_pkg::PRODUCT_ID_VALUE; // RQ17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : flash_bank_two_ctrl

/* File: tb/flash_bank_two_ctrl_monitor.sv */
// port-level assertion checker for the second-bank flash controller
module flash_bank_two_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        bank_wr,
  input wire logic [15:0] bank_wdata,
  input wire logic        array_start,
  input wire logic [1:0]  array_kind,
  input wire logic [31:0] array_addr,
  input wire logic [15:0] array_wdata,
  input wire logic        fetch_wait_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        ctl_wr_q;
  logic        bank_wr_q;
  logic        mass_q;
  logic        fw_wr_q;
  logic        fw_bit_q;
  logic [15:0] bdata_q;
  logic [31:0] tgt_q;
  always_ff @(posedge clk) begin
    ctl_wr_q  <= !rst && reg_wr && reg_addr == flash_bank_two_pkg::CONTROL_OFF;
    bank_wr_q <= !rst && bank_wr;
    fw_wr_q   <= !rst && reg_wr && reg_addr == flash_bank_two_pkg::FETCH_WAIT_OFF;
    mass_q    <= reg_wdata[flash_bank_two_pkg::CTL_MASS_ERASE_BIT];
    fw_bit_q  <= reg_wdata[flash_bank_two_pkg::WS_FETCH_WAIT_BIT];
    bdata_q   <= bank_wdata;
  end
  always_ff @(posedge clk) begin
    if (rst) tgt_q <= 32'h0;
    else if (reg_wr && reg_addr == flash_bank_two_pkg::TARGET_ADDR_OFF) tgt_q <= reg_wdata;
  end
  sequence key_pair_s;
    reg_wr && reg_addr == flash_bank_two_pkg::UNLOCK_KEY_OFF && reg_wdata == flash_bank_two_pkg::UNLOCK_KEY_FIRST ##1
    reg_wr && reg_addr == flash_bank_two_pkg::UNLOCK_KEY_OFF && reg_wdata == flash_bank_two_pkg::UNLOCK_KEY_SECOND;
  endsequence
  sequence ctl_read_s;
    reg_rd && reg_addr == flash_bank_two_pkg::CONTROL_OFF;
  endsequence
  sequence lock_write_s;
    reg_wr && reg_addr == flash_bank_two_pkg::CONTROL_OFF && reg_wdata[flash_bank_two_pkg::CTL_LOCK_BIT];
  endsequence
  chk_start_one_cycle: assert property (array_start |=> !array_start) else $error("start pulse too long");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data not idle");
  chk_id_read: assert property (reg_rd && reg_addr == flash_bank_two_pkg::PRODUCT_ID_OFF
    |=> reg_rdata == flash_bank_two_pkg::PRODUCT_ID_VALUE) else $error("identifier wrong");
  chk_key_unlock: assert property (key_pair_s ##1 ctl_read_s |=> !reg_rdata[flash_bank_two_pkg::CTL_LOCK_BIT])
    else $error("key pair did not unlock");
  chk_lock_set: assert property (lock_write_s ##2 ctl_read_s |=> reg_rdata[flash_bank_two_pkg::CTL_LOCK_BIT])
    else $error("lock not set by software");
  chk_fetch_wait: assert property ($changed(fetch_wait_state) |-> fw_wr_q && fetch_wait_state == fw_bit_q)
    else $error("wait state changed without write");
  chk_start_kind: assert property (array_start |-> (bank_wr_q && array_kind == flash_bank_two_pkg::OP_PROGRAM) ||
    (ctl_wr_q && array_kind == (mass_q ? flash_bank_two_pkg::OP_MASS_ERASE : flash_bank_two_pkg::OP_PAGE_ERASE)))
    else $error("start kind or cause wrong");
  chk_start_addr: assert property (array_start |-> array_addr == tgt_q) else $error("start address wrong");
  chk_prog_data: assert property (array_start && bank_wr_q |-> array_wdata == bdata_q)
    else $error("program data wrong");
endmodule : flash_bank_two_ctrl_monitor
bind flash_bank_two_ctrl flash_bank_two_ctrl_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_wr(bank_wr),
  .bank_wdata(bank_wdata), .array_start(array_start), .array_kind(array_kind), .array_addr(array_addr),
  .array_wdata(array_wdata), .fetch_wait_state(fetch_wait_state));

/* File: tb/flash_array_model.sv */
// flash array stand-in: answers each start with a done pulse after a chosen delay
module flash_array_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       array_start,
  input  wire logic [7:0] dly,
  output logic            array_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge clk) begin
    array_done <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else if (array_start) begin
      busy_r <= 1'b1;
      cnt_r  <= dly;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r     <= 1'b0;
      array_done <= 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : flash_array_model

/* File: tb/flash_bank_two_ctrl_tb.sv */
// self-checking bench for the second-bank flash controller
module flash_bank_two_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_KEY = flash_bank_two_pkg::UNLOCK_KEY_OFF, A_STA = flash_bank_two_pkg::STATUS_OFF,
    A_CTL = flash_bank_two_pkg::CONTROL_OFF, A_TGT = flash_bank_two_pkg::TARGET_ADDR_OFF,
    A_FW = flash_bank_two_pkg::FETCH_WAIT_OFF;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bank_wr = 1'b0, page_protected = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, array_addr, s_addr;
  logic [15:0] bank_wdata = 16'h0, array_cur_data = 16'hffff, array_wdata, s_wdata;
  logic [7:0]  dly = 8'h01;
  logic        array_start, array_done, fetch_wait_state, irq;
  flash_bank_two_pkg::op_kind_t array_kind, s_kind;
  int num_errors = 0, cmp_count = 0, n_start = 0, n_done = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (!rst && array_start) begin
      n_start++;
      s_kind  = array_kind;
      s_addr  = array_addr;
      s_wdata = array_wdata;
    end
    if (!rst && array_done) n_done++;
  end
  flash_bank_two_ctrl u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_wr(bank_wr), .bank_wdata(bank_wdata),
    .page_protected(page_protected), .array_cur_data(array_cur_data), .array_done(array_done),
    .array_start(array_start), .array_kind(array_kind), .array_addr(array_addr), .array_wdata(array_wdata),
    .fetch_wait_state(fetch_wait_state), .irq(irq));
  flash_array_model u_array (.clk(clk), .rst(rst), .array_start(array_start), .dly(dly), .array_done(array_done));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd_chk
  task automatic bank(input logic [15:0] d);
    @(posedge clk); bank_wr <= 1'b1; bank_wdata <= d;
    @(posedge clk); bank_wr <= 1'b0;
  endtask : bank
  task automatic wait_done();
    int base = n_done;
    for (int i = 0; i < 200 && n_done == base; i++) @(posedge clk);
    check(n_done - base, 1);
    repeat (4) @(posedge clk);
  endtask : wait_done
  task automatic t_reset();
    rd_chk(A_STA, flash_bank_two_pkg::STATUS_RST);
    rd_chk(A_CTL, flash_bank_two_pkg::CONTROL_RST);
    rd_chk(A_TGT, flash_bank_two_pkg::TARGET_ADDR_RST);
    rd_chk(A_FW, flash_bank_two_pkg::FETCH_WAIT_RST);
    rd_chk(flash_bank_two_pkg::PRODUCT_ID_OFF, flash_bank_two_pkg::PRODUCT_ID_VALUE);
    rd_chk(A_KEY, 32'h0);
    rd_chk(12'h0f0, 32'h0);
  endtask : t_reset
  task automatic t_locked_unlock();
    wr(A_CTL, 32'h1442);
    rd_chk(A_CTL, 32'h80);
    check(n_start, 0);
    wr(A_FW, 32'h1);
    #1 check(fetch_wait_state, 1'b0);
    wr(A_KEY, flash_bank_two_pkg::UNLOCK_KEY_FIRST);
    wr(A_KEY, 32'h0);
    rd_chk(A_CTL, 32'h80);
    @(posedge clk); reg_addr <= A_KEY; reg_wr <= 1'b1;
    reg_wdata <= flash_bank_two_pkg::UNLOCK_KEY_FIRST;
    @(posedge clk); reg_wdata <= flash_bank_two_pkg::UNLOCK_KEY_SECOND;
    @(posedge clk); reg_wr <= 1'b0; reg_rd <= 1'b1; reg_addr <= A_CTL;
    @(posedge clk); reg_rd <= 1'b0;
    #1 check(reg_rdata, 32'h0);
    wr(A_FW, 32'h1);
    #1 check(fetch_wait_state, 1'b1);
    rd_chk(A_FW, 32'h1);
  endtask : t_locked_unlock
  task automatic t_erase(input logic [31:0] ctl, input logic [31:0] kind, input logic irq_exp);
    int base = n_start;
    dly = 8'd20;
    wr(A_TGT, 32'h0800_1000 + ctl);
    wr(A_CTL, ctl);
    rd_chk(A_STA, 32'h1);
    check(n_start - base, 1);
    check(s_kind, kind);
    check(s_addr, 32'h0800_1000 + ctl);
    wait_done();
    rd_chk(A_STA, 32'h20);
    rd_chk(A_CTL, ctl & 32'hffff_ffbf);
    check(irq, irq_exp);
    wr(A_STA, 32'h20);
    rd_chk(A_STA, 32'h0);
    check(irq, 1'b0);
    wr(A_CTL, 32'h0);
  endtask : t_erase
  task automatic t_program();
    logic [31:0] st_exp[3];
    int base;
    st_exp = '{32'h4, 32'h20, 32'h10};
    dly = 8'd1;
    wr(A_CTL, 32'h401);
    base = n_start;
    bank(16'h1234);
    @(posedge clk);
    #1 check(n_start - base, 1);
    check(s_kind, flash_bank_two_pkg::OP_PROGRAM);
    check(s_wdata, 32'h1234);
    wait_done();
    rd_chk(A_STA, 32'h20);
    wr(A_STA, 32'h20);
    for (int k = 0; k < 3; k++) begin
      wr(A_FW, {30'h0, k == 1, 1'b1});
      page_protected <= (k == 2);
      array_cur_data <= (k == 2) ? 16'hffff : 16'h00ff;
      base = n_start;
      bank(16'h0f0f);
      repeat (8) @(posedge clk);
      check(n_start - base, (k == 1));
      rd_chk(A_STA, st_exp[k]);
      check(irq, (k != 1));
      wr(A_STA, st_exp[k]);
      rd_chk(A_STA, 32'h0);
    end
    page_protected <= 1'b0;
    wr(A_CTL, 32'h80);
    rd_chk(A_CTL, 32'h80);
  endtask : t_program
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_locked_unlock();
    t_erase(32'h1442, flash_bank_two_pkg::OP_PAGE_ERASE, 1'b1);
    t_erase(32'h0446, flash_bank_two_pkg::OP_MASS_ERASE, 1'b0);
    t_program();
    wrap_up();
  end
endmodule : flash_bank_two_ctrl_tb
